// File: common/trip_defs.svh
// Register map, field positions, reset values and timing constants
`ifndef TRIP_DEFS_SVH
`define TRIP_DEFS_SVH
// ==========================================
// Register byte offsets
`define OFS_CTRL       12'h000
`define OFS_RATED      12'h004
`define OFS_MOTOR      12'h008
`define OFS_OV_LVL     12'h00c
`define OFS_UV_LVL     12'h010
`define OFS_HS_LVL     12'h014
`define OFS_CLIM_MS    12'h018
`define OFS_STATUS     12'h01c
`define OFS_HIST0      12'h020
`define OFS_HIST4      12'h030
// ==========================================
// Control fields
`define CTRL_RST_BIT   0
`define CTRL_LOSS_LO   1
`define CTRL_LOSS_HI   2
// ==========================================
// Reset values
`define RST_RATED      16'h0100
`define RST_OV         12'hc00
`define RST_UV         12'h400
`define RST_HS         12'h800
`define RST_CLIM       16'h03e8
// ==========================================
// Thresholds in percent of rated current
`define PCT_OC         200
`define PCT_CLIM       180
`define PCT_OL         150
`define PCT_PHASE      50
`define PCT_FULL       100
// ==========================================
// Timing and history depth
`define CLK_NS         10
`define TICK_NS        1000000
`define OL_MS          60000
`define PHASE_MS       60000
`define HIST_DEPTH     5
`endif

// File: common/trip_pkg.sv
// Types shared by the fault-trip supervisor
`default_nettype none
package trip_pkg;
  typedef enum logic [3:0] {
    FC_NONE     = 4'h0,
    FC_OC       = 4'h1,
    FC_OV       = 4'h2,
    FC_CLIM     = 4'h3,
    FC_HS       = 4'h4,
    FC_MOTOR    = 4'h5,
    FC_UV       = 4'h6,
    FC_IN_PH    = 4'h7,
    FC_OUT_PH   = 4'h8,
    FC_OVERLOAD = 4'h9,
    FC_EXT_A    = 4'ha,
    FC_EXT_B    = 4'hb,
    FC_CUTOFF   = 4'hc
  } fault_code_t;

  typedef enum logic [1:0] {
    LOSS_CONTINUE = 2'h0,
    LOSS_FREE_RUN = 2'h1,
    LOSS_DECEL    = 2'h2
  } loss_action_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_CUTOFF = 2'b01,
    ST_TRIP   = 2'b11
  } state_t;

  typedef struct packed {
    fault_code_t code;
    logic [3:0]  op_status;
  } hist_entry_t;

  typedef struct packed {
    logic [15:0] current;
    logic [11:0] dc_bus;
    logic [11:0] hs_temp;
    logic [3:0]  op_status;
    logic        in_phase_open;
    logic        out_phase_open;
    logic        emergency_cutoff_input;
    logic        ext_fault_no;
    logic        ext_fault_nc;
    logic        reset_terminal_pair;
    logic        keypad_reset;
    logic        ref_lost;
  } sense_t;
endpackage
`default_nettype wire

// File: design/fault_history.sv
// Five-entry fault history, newest in slot 0
`timescale 1ns/1ps
`default_nettype none
`include "trip_defs.svh"
module fault_history (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // New entry
  input  wire logic                 push,
  input  wire trip_pkg::hist_entry_t entry_in,
  // Stored entries
  output trip_pkg::hist_entry_t     fault_history_slot [`HIST_DEPTH]
);
  import trip_pkg::*;

  hist_entry_t next_slot [`HIST_DEPTH];

  always_comb begin
    for (int i = 0; i < `HIST_DEPTH; i++) begin
      next_slot[i] = fault_history_slot[i];
    end
    if (push) begin
      next_slot[0] = entry_in;
      for (int i = 1; i < `HIST_DEPTH; i++) begin
        next_slot[i] = fault_history_slot[i-1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `HIST_DEPTH; i++) begin
        fault_history_slot[i] <= '0;
      end
    end else begin
      fault_history_slot <= next_slot;
    end
  end
endmodule
`default_nettype wire

// File: design/overload_integrator.sv
// Inverse-time overload accumulator, one step per millisecond tick
`timescale 1ns/1ps
`default_nettype none
`include "trip_defs.svh"
module overload_integrator (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Inputs
  input  wire logic        tick,
  input  wire logic        clear,
  input  wire logic [15:0] current,
  input  wire logic [15:0] rated,
  // Result
  output logic             over
);
  localparam logic [31:0] BUDGET = 32'((`PCT_OL - `PCT_FULL) * `OL_MS / `PCT_FULL);

  logic [47:0] acc;
  logic [47:0] next_acc;
  logic [47:0] limit;
  logic        next_over;

  // Excess above rated accumulates; budget of 50% excess over one minute
  always_comb begin
    limit    = 48'(rated) * 48'(BUDGET);
    next_acc = acc;
    if (clear) begin
      next_acc = '0;
    end else if (tick) begin
      if (current > rated) begin
        next_acc = acc + 48'(current - rated);
      end else if (acc > 48'(rated - current)) begin
        next_acc = acc - 48'(rated - current);
      end else begin
        next_acc = '0;
      end
    end
    next_over = !clear && (next_acc >= limit) && (rated != 16'h0000);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc  <= '0;
      over <= 1'b0;
    end else begin
      acc  <= next_acc;
      over <= next_over;
    end
  end
endmodule
`default_nettype wire

// File: design/drive_fault_trip_supervisor.sv
// Fault-trip supervisor: protection checks, trip latch, history and APB registers
// Operation
// - Any fault disables output and shows its code in the present fault display.
// - Keep the last five faults, each with operating status at that moment.
// - Trip on over-current above 200% of rated current.
// - Trip on over-voltage when DC bus exceeds its rated level.
// - Trip when current stays at 180% longer than the programmed limit time.
// - Motor thermal model trips on overload; 150% allowed for one minute.
// - Trip on heat-sink over-temperature from the measured temperature.
// - Trip on low voltage when DC bus falls below the detection level.
// - Input phase open with load above 50% for over a minute trips.
// - Trip when output current monitoring shows an open output phase.
// - Cut-off input disables output at once; release resumes without reset.
// - Drive overload trip, inverse time, 150% for one minute.
// - Normally-open external contact closing trips with external fault A.
// - Normally-closed external contact opening trips with external fault B.
// - Reference loss: continue, decelerate to stop, or coast to stop.
// - Loss action code 0 continue (default), 1 free run, 2 decelerate.
// - History slot 0 holds the newest fault; older ones shift upward.
// - Keypad, terminal or power-cycle reset clears trip and retry counter.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "trip_defs.svh"
module drive_fault_trip_supervisor #(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
) (
  // APB
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Pins from sensors and terminals
  input  wire trip_pkg::sense_t sense,
  // Drive control
  output logic               output_enable,
  output logic               decel_request,
  output trip_pkg::fault_code_t present_fault_display
);
  import trip_pkg::*;
  // ==========================================
  // Input synchronisers
  sense_t     sync1;
  sense_t     s;
  logic [1:0] warm;  // Checks wait until s holds real pin samples, not reset zeros
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      s     <= '0;
      warm  <= 2'b00;
    end else begin
      sync1 <= sense;
      s     <= sync1;
      warm  <= {warm[0], 1'b1};
    end
  end
  // ==========================================
  // Registers
  logic [15:0]  rated;
  logic [15:0]  motor_rated;
  logic [11:0]  ov_lvl;
  logic [11:0]  uv_lvl;
  logic [11:0]  hs_lvl;
  logic [15:0]  clim_ms;
  loss_action_t loss_action;
  logic         soft_reset;
  logic [15:0]  next_rated;
  logic [15:0]  next_motor_rated;
  logic [11:0]  next_ov_lvl;
  logic [11:0]  next_uv_lvl;
  logic [11:0]  next_hs_lvl;
  logic [15:0]  next_clim_ms;
  loss_action_t next_loss_action;
  logic         next_soft_reset;
  logic [31:0]  next_prdata;
  logic         next_pready;
  logic         next_pslverr;
  logic         wr_en;
  logic         setup;
  hist_entry_t  fault_history_slot [`HIST_DEPTH];
  state_t       state;
  logic [7:0]   retry_count;
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `OFS_HIST4);
  endfunction
  function automatic logic [31:0] read_word(input logic [11:0] a);
    read_word = 32'h0000_0000;
    case (a)
      `OFS_CTRL:    read_word = {29'h0, loss_action, 1'b0};
      `OFS_RATED:   read_word = {16'h0, rated};
      `OFS_MOTOR:   read_word = {16'h0, motor_rated};
      `OFS_OV_LVL:  read_word = {20'h0, ov_lvl};
      `OFS_UV_LVL:  read_word = {20'h0, uv_lvl};
      `OFS_HS_LVL:  read_word = {20'h0, hs_lvl};
      `OFS_CLIM_MS: read_word = {16'h0, clim_ms};
      `OFS_STATUS:  read_word = {16'h0, retry_count, state, output_enable, decel_request, present_fault_display};
      default:      read_word = (a >= `OFS_HIST0) ? {24'h0, fault_history_slot[3'((a - `OFS_HIST0) >> 2)]} : 32'h0;
    endcase
  endfunction
  // Zero-wait slave: answer prepared in setup, pready high in access
  always_comb begin
    setup            = psel && !penable;
    wr_en            = psel && penable && pready && pwrite && !pslverr;
    next_pready      = setup;
    next_pslverr     = setup && !mapped(paddr);
    next_prdata      = (setup && !pwrite && mapped(paddr)) ? read_word(paddr) : prdata;
    next_rated       = rated;
    next_motor_rated = motor_rated;
    next_ov_lvl      = ov_lvl;
    next_uv_lvl      = uv_lvl;
    next_hs_lvl      = hs_lvl;
    next_clim_ms     = clim_ms;
    next_loss_action = loss_action;
    next_soft_reset  = 1'b0;
    if (wr_en) begin
      case (paddr)
        `OFS_CTRL: begin
          next_soft_reset = pwdata[`CTRL_RST_BIT];
          if (pwdata[`CTRL_LOSS_HI:`CTRL_LOSS_LO] != 2'h3) begin
            next_loss_action = loss_action_t'(pwdata[`CTRL_LOSS_HI:`CTRL_LOSS_LO]);
          end
        end
        `OFS_RATED:   next_rated = pwdata[15:0];
        `OFS_MOTOR:   next_motor_rated = pwdata[15:0];
        `OFS_OV_LVL:  next_ov_lvl = pwdata[11:0];
        `OFS_UV_LVL:  next_uv_lvl = pwdata[11:0];
        `OFS_HS_LVL:  next_hs_lvl = pwdata[11:0];
        `OFS_CLIM_MS: next_clim_ms = pwdata[15:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      rated       <= `RST_RATED;
      motor_rated <= `RST_RATED;
      ov_lvl      <= `RST_OV;
      uv_lvl      <= `RST_UV;
      hs_lvl      <= `RST_HS;
      clim_ms     <= `RST_CLIM;
      loss_action <= LOSS_CONTINUE;
      soft_reset  <= 1'b0;
    end else begin
      prdata      <= next_prdata;
      pready      <= next_pready;
      pslverr     <= next_pslverr;
      rated       <= next_rated;
      motor_rated <= next_motor_rated;
      ov_lvl      <= next_ov_lvl;
      uv_lvl      <= next_uv_lvl;
      hs_lvl      <= next_hs_lvl;
      clim_ms     <= next_clim_ms;
      loss_action <= next_loss_action;
      soft_reset  <= next_soft_reset;
    end
  end
  // ==========================================
  // Millisecond tick and timers
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic        tick;
  logic [15:0] clim_cnt;
  logic [15:0] next_clim_cnt;
  logic [15:0] phase_cnt;
  logic [15:0] next_phase_cnt;
  logic        at_clim;
  logic        in_phase_load;
  logic        fault_reset;
  function automatic logic pct_at_least(input logic [15:0] cur, input logic [15:0] rat,
                                        input int pct);
    pct_at_least = (32'(cur) * 32'(`PCT_FULL)) >= (32'(rat) * 32'(pct));
  endfunction
  always_comb begin
    tick          = (tick_cnt == 32'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    fault_reset   = soft_reset || s.reset_terminal_pair || s.keypad_reset;
    at_clim       = pct_at_least(s.current, rated, `PCT_CLIM);
    in_phase_load = (32'(s.current) * 32'(`PCT_FULL)) > (32'(rated) * 32'(`PCT_PHASE));
    next_clim_cnt = clim_cnt;
    if (!at_clim) begin
      next_clim_cnt = 16'h0;
    end else if (tick && clim_cnt <= clim_ms) begin
      next_clim_cnt = clim_cnt + 16'h1;
    end
    next_phase_cnt = phase_cnt;
    // open phase under load for a minute
    if (!(s.in_phase_open && in_phase_load)) begin
      next_phase_cnt = 16'h0;
    end else if (tick && phase_cnt <= 16'(`PHASE_MS)) begin
      next_phase_cnt = phase_cnt + 16'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt  <= 32'h0;
      clim_cnt  <= 16'h0;
      phase_cnt <= 16'h0;
    end else begin
      tick_cnt  <= next_tick_cnt;
      clim_cnt  <= next_clim_cnt;
      phase_cnt <= next_phase_cnt;
    end
  end
  logic motor_over;
  overload_integrator motor_thermal (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .clear   (fault_reset),
    .current (s.current),
    .rated   (motor_rated),
    .over    (motor_over)
  );
  logic drive_over;
  overload_integrator drive_overload (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .clear   (fault_reset),
    .current (s.current),
    .rated   (rated),
    .over    (drive_over)
  );
  // ==========================================
  // Fault detection and trip state
  fault_code_t detected;
  fault_code_t next_display;
  state_t      next_state;
  logic        push;
  logic [7:0]  next_retry_count;
  logic        next_output_enable;
  logic        next_decel_request;
  always_comb begin
    detected = FC_NONE;
    if (32'(s.current) * 32'(`PCT_FULL) > 32'(rated) * 32'(`PCT_OC)) begin
      detected = FC_OC;                       // over-current
    end else if (s.dc_bus > ov_lvl) begin
      detected = FC_OV;                       // over-voltage
    end else if (clim_cnt > clim_ms) begin
      detected = FC_CLIM;                     // current limit
    end else if (s.hs_temp > hs_lvl) begin
      detected = FC_HS;                       // heat sink
    end else if (motor_over) begin
      detected = FC_MOTOR;                    // motor thermal
    end else if (s.dc_bus < uv_lvl) begin
      detected = FC_UV;                       // low voltage
    end else if (phase_cnt > 16'(`PHASE_MS)) begin
      detected = FC_IN_PH;                    // input phase
    end else if (s.out_phase_open) begin
      detected = FC_OUT_PH;                   // output phase
    end else if (drive_over) begin
      detected = FC_OVERLOAD;                 // drive overload
    end else if (s.ext_fault_no) begin
      detected = FC_EXT_A;                    // contact closed
    end else if (!s.ext_fault_nc) begin
      detected = FC_EXT_B;                    // contact opened
    end
    next_state       = state;
    next_display     = present_fault_display;
    next_retry_count = retry_count;
    push             = 1'b0;
    case (state)
      ST_TRIP: begin
        // reset clears trip and retry count
        if (fault_reset) begin
          next_retry_count = 8'h00;
          next_state       = s.emergency_cutoff_input ? ST_CUTOFF : ST_RUN;
          next_display     = s.emergency_cutoff_input ? FC_CUTOFF : FC_NONE;
        end
      end
      ST_RUN, ST_CUTOFF: begin
        // cut-off follows the input level, no latch
        next_state   = s.emergency_cutoff_input ? ST_CUTOFF : ST_RUN;
        next_display = s.emergency_cutoff_input ? FC_CUTOFF : FC_NONE;
      end
      default: begin
        next_state   = ST_TRIP;
        next_display = FC_NONE;
      end
    endcase
    // a new fault trips and displays its code; it wins over a reset
    if (warm[1] && detected != FC_NONE && (state != ST_TRIP || fault_reset)) begin
      next_state       = ST_TRIP;
      next_display     = detected;
      push             = 1'b1;
      next_retry_count = (state == ST_TRIP) ? 8'h00 : retry_count + 8'h01;
    end
    next_output_enable = warm[1] && (next_state == ST_RUN) &&
                         !(s.ref_lost && loss_action == LOSS_FREE_RUN);
    next_decel_request = next_output_enable && s.ref_lost && loss_action == LOSS_DECEL;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                 <= ST_RUN;
      present_fault_display <= FC_NONE;
      retry_count           <= 8'h00;
      output_enable         <= 1'b0;
      decel_request         <= 1'b0;
    end else begin
      state                 <= next_state;
      present_fault_display <= next_display;
      retry_count           <= next_retry_count;
      output_enable         <= next_output_enable;
      decel_request         <= next_decel_request;
    end
  end
  // snapshot of code and operating status
  fault_history history (
    .pclk               (pclk),
    .presetn            (presetn),
    .push               (push),
    .entry_in           ({detected, s.op_status}),
    .fault_history_slot (fault_history_slot)
  );
endmodule
`default_nettype wire

// File: bench/trip_properties.sv
// Port-level checks for the fault-trip supervisor
`timescale 1ns/1ps
`default_nettype none
`include "trip_defs.svh"
module trip_properties #(
  parameter int TICK_CYCLES = 100000
) (
  // APB
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Pins
  input wire trip_pkg::sense_t      sense,
  // Drive control
  input wire logic                  output_enable,
  input wire logic                  decel_request,
  input wire trip_pkg::fault_code_t present_fault_display
);
  import trip_pkg::*;
  logic quiet;
  // ==========================================
  // No reset source of any kind and no cut-off input pending
  assign quiet = !sense.keypad_reset && !sense.reset_terminal_pair && !sense.emergency_cutoff_input
                 && !(psel && pwrite && paddr == `OFS_CTRL && pwdata[0]);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Assertions
  a_enable_clear: assert property (output_enable |-> present_fault_display == FC_NONE)
    else $error("output enabled while a fault is shown");
  a_cutoff_stop: assert property (sense.emergency_cutoff_input [*3] |=> !output_enable)
    else $error("cut-off did not stop the output");
  a_cutoff_resume: assert property ((!sense.emergency_cutoff_input) [*3]
    ##0 present_fault_display == FC_CUTOFF |=> present_fault_display != FC_CUTOFF)
    else $error("cut-off code outlived its input");
  a_exta_stop: assert property (sense.ext_fault_no [*3] |=> !output_enable)
    else $error("closed contact A left output on");
  a_extb_stop: assert property ((!sense.ext_fault_nc) [*3] |=> !output_enable)
    else $error("open contact B left output on");
  a_trip_latched: assert property (quiet [*3] ##0
    (present_fault_display != FC_NONE && present_fault_display != FC_CUTOFF)
    |=> $stable(present_fault_display) && !output_enable)
    else $error("trip released without a reset");
  a_ready_timing: assert property (pready == $past(psel && !penable))
    else $error("pready not one cycle after setup");
  a_error_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside the access cycle");
  cover property (present_fault_display == FC_CUTOFF);
  cover property ($fell(output_enable));
  cover property (pslverr);
  cover property (decel_request);
endmodule
`default_nettype wire

// File: bench/drive_plant_model.sv
// Power stage and sensor front end facing the supervisor
`timescale 1ns/1ps
`default_nettype none
module drive_plant_model (
  // Bench command
  input  wire trip_pkg::sense_t cmd,
  // Supervisor output
  input  wire logic             output_enable,
  // Pins
  output trip_pkg::sense_t      sense
);
  import trip_pkg::*;
  // Bridge off means no current, so a trip is not masked by stale load
  always_comb begin
    sense = cmd;
    if (!output_enable)
      sense.current = 16'h0000;
  end
endmodule
`default_nettype wire

// File: bench/drive_fault_trip_supervisor_bench.sv
// Self-checking bench for the fault-trip supervisor
`timescale 1ns/1ps
`default_nettype none
`include "trip_defs.svh"
`define CHK(nm, ex, got) begin \
  tests_run++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module drive_fault_trip_supervisor_bench;
  import trip_pkg::*;
  typedef struct packed {
    logic [15:0] cur;
    logic [11:0] bus;
    logic [11:0] hs;
    logic [3:0]  pins;
    fault_code_t code;
  } row_t;
  localparam int TICK_CYCLES = 10;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        output_enable, decel_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  fault_code_t present_fault_display;
  sense_t      cmd, sense, nominal;
  int          fail_count, tests_run, cyc;
  // Pins: in phase, out phase, contact A, contact B
  row_t        rows [9] = '{
    '{16'h0201, 12'h800, 12'h100, 4'h1, FC_OC},
    '{16'h0100, 12'hc01, 12'h100, 4'h1, FC_OV},
    '{16'h0100, 12'h800, 12'h801, 4'h1, FC_HS},
    '{16'h0100, 12'h3ff, 12'h100, 4'h1, FC_UV},
    '{16'h0100, 12'h800, 12'h100, 4'h5, FC_OUT_PH},
    '{16'h0100, 12'h800, 12'h100, 4'h3, FC_EXT_A},
    '{16'h0100, 12'h800, 12'h100, 4'h0, FC_EXT_B},
    '{16'h0201, 12'h800, 12'h100, 4'h3, FC_OC},
    '{16'h0100, 12'h3ff, 12'h100, 4'h5, FC_UV}};

  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  drive_fault_trip_supervisor #(.TICK_CYCLES(TICK_CYCLES)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
    .output_enable(output_enable), .decel_request(decel_request), .present_fault_display(present_fault_display));
  drive_plant_model u_plant (.cmd(cmd), .output_enable(output_enable), .sense(sense));

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One transfer, then one idle edge so back-to-back calls never clash
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) fail_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic clear_trip(input int how);
    if (how == 0) apb(1'b1, `OFS_CTRL, 32'h1);
    else begin
      cmd.reset_terminal_pair <= (how == 1);
      cmd.keypad_reset <= (how == 2);
      tick(3);
      cmd <= nominal;
    end
    tick(6);
  endtask

  task automatic wait_trip(input int lim);
    int n = 0;
    while (present_fault_display === FC_NONE && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    nominal = '{current: 16'h0100, dc_bus: 12'h800, hs_temp: 12'h100, ext_fault_nc: 1'b1, default: '0};
    cmd = nominal;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    tick(2);
    presetn <= 1'b1;
    tick(5);
    `CHK("enable", 1'b1, output_enable)
    apb(1'b0, `OFS_RATED, 32'h0);
    `CHK("rated", 32'h100, r)
    apb(1'b0, 12'h034, 32'h0);
    `CHK("unmapped", 1'b1, e)
    // ==========================================
    // Table of single and simultaneous faults
    for (int i = 0; i < 9; i++) begin
      cmd.current <= rows[i].cur;
      cmd.dc_bus <= rows[i].bus;
      cmd.hs_temp <= rows[i].hs;
      {cmd.in_phase_open, cmd.out_phase_open, cmd.ext_fault_no, cmd.ext_fault_nc} <= rows[i].pins;
      cmd.op_status <= i[3:0];
      tick(6);
      `CHK("code", rows[i].code, present_fault_display)
      `CHK("off", 1'b0, output_enable)
      apb(1'b0, `OFS_HIST0, 32'h0);
      `CHK("hist0", {24'h0, rows[i].code, i[3:0]}, r)
      apb(1'b0, `OFS_STATUS, 32'h0);
      `CHK("retry", 8'h01, r[15:8])
      cmd <= nominal;
      tick(8);
      `CHK("latched", rows[i].code, present_fault_display)
      clear_trip(i % 3);
      `CHK("resumed", 1'b1, output_enable)
      apb(1'b0, `OFS_STATUS, 32'h0);
      `CHK("retry clr", 8'h00, r[15:8])
    end
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 12'(`OFS_HIST0 + 4 * k), 32'h0);
      `CHK("history", {24'h0, rows[8-k].code, 4'(8 - k)}, r)
    end
    // ==========================================
    // Cut-off, current limit, reference loss, motor model
    cmd.emergency_cutoff_input <= 1'b1;
    tick(5);
    `CHK("cut off", 1'b0, output_enable)
    `CHK("cut code", FC_CUTOFF, present_fault_display)
    cmd <= nominal;
    tick(5);
    `CHK("cut back", 1'b1, output_enable)
    apb(1'b1, `OFS_CLIM_MS, 32'h3);
    cmd.current <= 16'h01cd;
    tick(20);
    `CHK("limit early", FC_NONE, present_fault_display)
    wait_trip(100);
    `CHK("limit", FC_CLIM, present_fault_display)
    cmd <= nominal;
    clear_trip(0);
    cmd.ref_lost <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, `OFS_CTRL, 32'(m) << 1);
      tick(5);
      `CHK("loss run", m != 1, output_enable)
      `CHK("loss decel", m == 2, decel_request)
      `CHK("loss code", FC_NONE, present_fault_display)
    end
    cmd <= nominal;
    clear_trip(0);
    apb(1'b1, `OFS_MOTOR, 32'h1);
    wait_trip(3000);
    `CHK("thermal", FC_MOTOR, present_fault_display)
    conclude();
  end
endmodule
bind drive_fault_trip_supervisor trip_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
  .output_enable(output_enable), .decel_request(decel_request), .present_fault_display(present_fault_display));
`default_nettype wire
